/* core/sbc_bank_config.sv */
// Purpose: Two SDRAM bank configuration registers, address decode and mode register set issue
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes: One shared command issuer; bank 0 wins when both banks request a mode set
////////////////////////////////////////////////////////////////////////////////
//
// Implementation choice: register access over Wishbone.
module sbc_bank_config (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o,
    input wire logic [31:0] mem_addr,
    input wire logic mem_req,
    output logic [1:0] bank_hit,
    output logic [1:0][31:0] bank_start,
    output logic [1:0] precharge_select,
    output logic [1:0][1:0] cas_latency_clocks,
    output logic [1:0] internal_bank_count,
    output logic [1:0][1:0] bank_bus_width,
    output logic [1:0][3:0] column_bits,
    output logic [1:0] mode_load_request,
    output logic [1:0] sdram_cs_n,
    output logic sdram_ras_n,
    output logic sdram_cas_n,
    output logic sdram_we_n,
    output logic [sbc_pkg::SBC_MODE_W-1:0] sdram_mode_addr
);
    logic [1:0][31:0] cfg;
    logic [31:0] byte_mask;
    logic access;
    logic [1:0] reg_write;
    logic [1:0] reg_sel;
    logic [1:0] issuable;
    logic issue_start;
    logic issue_bank;
    logic issue_busy;
    logic issue_done;
    logic issue_done_bank;
    logic [1:0] next_hit;
    logic [1:0] mrs_set;
    logic [1:0] mrs_clear;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign reg_sel[0] = wb_adr_i == sbc_pkg::SBC_BANK0_ADDR;
    assign reg_sel[1] = wb_adr_i == sbc_pkg::SBC_BANK1_ADDR;
    assign reg_write = (access && wb_we_i) ? reg_sel : 2'h0;
    assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // One-cycle ack; unmapped addresses still answer, reading zero
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (access && !wb_we_i) begin
            wb_dat_o <= reg_sel[0] ? cfg[0] : (reg_sel[1] ? cfg[1] : 32'h0000_0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    // Mode-load bit stays set until its command and recovery wait are done, and clears at once on a bank that is not issuable; a new write of one wins over the clear
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bank
            always_ff @(posedge clk) begin
                if (rst) begin
                    cfg[b] <= sbc_pkg::SBC_CFG_RESET;
                end else begin
                    if (reg_write[b]) begin
                        // Reserved bits never store
                        cfg[b] <= (cfg[b] & ~(byte_mask & sbc_pkg::SBC_CFG_WMASK))
                            | (wb_dat_i & byte_mask & sbc_pkg::SBC_CFG_WMASK);
                    end
                    // Placed after the write so a write that leaves bit 15 alone cannot keep it pending
                    if (mrs_clear[b] && !mrs_set[b]) begin
                        cfg[b][sbc_pkg::SBC_MRS_BIT] <= 1'b0;
                    end
                end
            end

            assign mrs_set[b] = reg_write[b] && byte_mask[sbc_pkg::SBC_MRS_BIT] && wb_dat_i[sbc_pkg::SBC_MRS_BIT];
            assign mrs_clear[b] = (issue_done && issue_done_bank == 1'(b))
                || (cfg[b][sbc_pkg::SBC_MRS_BIT] && !issuable[b]);

            assign bank_start[b] = sbc_pkg::sbc_start(cfg[b]);
            assign precharge_select[b] = cfg[b][sbc_pkg::SBC_PRE_BIT];
            assign cas_latency_clocks[b] = sbc_pkg::sbc_cl_clocks(cfg[b][sbc_pkg::SBC_CL_HI:sbc_pkg::SBC_CL_LO]);
            assign internal_bank_count[b] = cfg[b][sbc_pkg::SBC_NB_BIT];
            assign bank_bus_width[b] = cfg[b][sbc_pkg::SBC_BW_HI:sbc_pkg::SBC_BW_LO];
            assign column_bits[b] = sbc_pkg::sbc_col_bits(cfg[b][sbc_pkg::SBC_COL_HI:sbc_pkg::SBC_COL_LO]);
            assign mode_load_request[b] = cfg[b][sbc_pkg::SBC_MRS_BIT];
            // Disabled bank or reserved latency gets no command
            assign issuable[b] = bank_bus_width[b] != sbc_pkg::SBC_BW_OFF
                && cas_latency_clocks[b] != 2'h0;
            assign next_hit[b] = mem_req && sbc_pkg::sbc_in_range(cfg[b], mem_addr);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; registered so the select is a clean flop output
    always_ff @(posedge clk) begin
        if (rst) begin
            bank_hit <= 2'h0;
        end else begin
            bank_hit <= next_hit[0] ? 2'h1 : next_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode register set issue
    assign issue_bank = !(mode_load_request[0] && issuable[0]);
    // The done cycle still shows the pending bit; starting then would send a second command
    assign issue_start = !issue_busy && !issue_done && |(mode_load_request & issuable) && !(|reg_write);

    sbc_mrs_issuer u_issuer (
        .clk(clk),
        .rst(rst),
        .start(issue_start),
        .start_bank(issue_bank),
        .cl_clocks(cas_latency_clocks[issue_bank]),
        .cs_n(sdram_cs_n),
        .ras_n(sdram_ras_n),
        .cas_n(sdram_cas_n),
        .we_n(sdram_we_n),
        .mode_addr(sdram_mode_addr),
        .busy(issue_busy),
        .done(issue_done),
        .done_bank(issue_done_bank)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_mrs_written(int k);
        reg_write[k] && wb_sel_i[1] && wb_dat_i[sbc_pkg::SBC_MRS_BIT];
    endsequence

    // Issuer free, no write in flight, bank still pending and usable
    sequence s_mrs_ready(int k);
        mode_load_request[k] && issuable[k] && !issue_busy && !issue_done && !(|reg_write);
    endsequence

    sequence s_mrs_cmd(int k);
        !sdram_cs_n[k] && !sdram_ras_n && !sdram_cas_n && !sdram_we_n;
    endsequence

    chk_reset_value: assert property ($fell(rst) |-> cfg[0] == sbc_pkg::SBC_CFG_RESET
        && cfg[1] == sbc_pkg::SBC_CFG_RESET)
        else $error("configuration not at reset value");

    chk_reserved_zero: assert property (((cfg[0] | cfg[1]) & ~sbc_pkg::SBC_CFG_WMASK) == 32'h0000_0000)
        else $error("reserved configuration bit set");

    chk_readback_path: assert property (access && !wb_we_i && reg_sel[1] |=> wb_ack_o && wb_dat_o == $past(cfg[1]))
        else $error("bank 1 read data wrong");

    chk_write_store: assert property (reg_write[0] && wb_sel_i == 4'hF |=>
        cfg[0][31:16] == $past(wb_dat_i[31:16] & sbc_pkg::SBC_CFG_WMASK[31:16]))
        else $error("bank 0 write not stored");

    chk_mrs_issue_b0: assert property (s_mrs_written(0) ##1 s_mrs_ready(0) |=> s_mrs_cmd(0))
        else $error("mode set not issued to bank 0");

    chk_mrs_issue_b1: assert property (s_mrs_written(1) ##1 s_mrs_ready(1)
        ##0 !(mode_load_request[0] && issuable[0]) |=> s_mrs_cmd(1))
        else $error("mode set not issued to bank 1");

    chk_mode_latency: assert property (!sdram_cs_n[0] |->
        sdram_mode_addr[sbc_pkg::SBC_MODE_CL_LO+1:sbc_pkg::SBC_MODE_CL_LO] == $past(cas_latency_clocks[0]))
        else $error("mode word latency mismatch");

    chk_disabled_quiet: assert property (bank_bus_width[0] == sbc_pkg::SBC_BW_OFF
        && $past(bank_bus_width[0]) == sbc_pkg::SBC_BW_OFF |-> !bank_hit[0] && sdram_cs_n[0])
        else $error("disabled bank 0 driven");

    chk_hit_start: assert property (mem_req && mem_addr == bank_start[1] && !next_hit[0]
        && bank_bus_width[1] != sbc_pkg::SBC_BW_OFF && cfg[1][2:0] == 3'h1 |=> bank_hit == 2'h2)
        else $error("bank 1 start address not selected");

    chk_latency_map: assert property (cfg[1][sbc_pkg::SBC_CL_HI:sbc_pkg::SBC_CL_LO] == 2'h2 |->
        cas_latency_clocks[1] == 2'h3)
        else $error("latency code 10 not three clocks");

    chk_column_map: assert property (cfg[1][sbc_pkg::SBC_COL_HI:sbc_pkg::SBC_COL_LO] == 2'h1 |->
        column_bits[1] == 4'h9)
        else $error("column code 01 not nine bits");

    chk_width_bank: assert property (reg_write[0] && wb_sel_i[0] |=>
        internal_bank_count[0] == $past(wb_dat_i[sbc_pkg::SBC_NB_BIT])
        && bank_bus_width[0] == $past(wb_dat_i[sbc_pkg::SBC_BW_HI:sbc_pkg::SBC_BW_LO]))
        else $error("bank count or width output wrong");

    chk_precharge_bit: assert property (reg_write[1] && wb_sel_i[1] |=>
        precharge_select[1] == $past(wb_dat_i[sbc_pkg::SBC_PRE_BIT]))
        else $error("precharge select not updated");

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule // sbc_bank_config

/* core/sbc_mrs_issuer.sv */
// Purpose: Drives one mode register set command and waits out the mode-set recovery time
// Assumes: Caller starts it only while busy is low
// Notes: Command pins come from flip-flops
module sbc_mrs_issuer (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic start_bank,
    input wire logic [1:0] cl_clocks,
    output logic [1:0] cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [sbc_pkg::SBC_MODE_W-1:0] mode_addr,
    output logic busy,
    output logic done,
    output logic done_bank
);
    sbc_pkg::sbc_mrs_state_type state;
    logic [3:0] wait_count;

    assign busy = state != sbc_pkg::SBC_IDLE;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= sbc_pkg::SBC_IDLE;
            wait_count <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                sbc_pkg::SBC_IDLE: begin
                    if (start) begin
                        state <= sbc_pkg::SBC_CMD;
                    end
                end
                sbc_pkg::SBC_CMD: begin
                    state <= sbc_pkg::SBC_WAIT;
                    wait_count <= 4'(sbc_pkg::SBC_MRD_CYCLES);
                end
                sbc_pkg::SBC_WAIT: begin
                    // Recovery time before the bank may be used again
                    if (wait_count <= 4'h1) begin
                        state <= sbc_pkg::SBC_IDLE;
                        done <= 1'b1;
                    end else begin
                        wait_count <= wait_count - 4'h1;
                    end
                end
                default: state <= sbc_pkg::SBC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n <= 2'h3;
            {ras_n, cas_n, we_n} <= sbc_pkg::SBC_CMD_NOP;
            mode_addr <= '0;
            done_bank <= 1'b0;
        end else if (state == sbc_pkg::SBC_IDLE && start) begin
            cs_n <= start_bank ? 2'h1 : 2'h2;
            {ras_n, cas_n, we_n} <= sbc_pkg::SBC_CMD_MRS;
            // Burst length 1, sequential, CAS latency in clocks
            mode_addr <= sbc_pkg::SBC_MODE_W'({cl_clocks, {sbc_pkg::SBC_MODE_CL_LO{1'b0}}});
            done_bank <= start_bank;
        end else begin
            cs_n <= 2'h3;
            {ras_n, cas_n, we_n} <= sbc_pkg::SBC_CMD_NOP;
        end
    end
endmodule // sbc_mrs_issuer

/* core/sbc_pkg.sv */
// Purpose: Shared constants, types and decode functions for the SDRAM bank configuration block
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register bus
// Notes: Register addresses are full byte addresses
package sbc_pkg;
    localparam logic [31:0] SBC_BANK0_ADDR = 32'hFFF0_1008;
    localparam logic [31:0] SBC_BANK1_ADDR = 32'hFFF0_100C;
    localparam logic [31:0] SBC_CFG_RESET = 32'h0000_0800;
    // Writable bits; everything else is reserved and reads zero
    localparam logic [31:0] SBC_CFG_WMASK = 32'hFFF8_B8FF;

    localparam int SBC_BASE_HI = 31;
    localparam int SBC_BASE_LO = 19;
    localparam int SBC_BASE_SHIFT = 18;
    localparam int SBC_MRS_BIT = 15;
    localparam int SBC_PRE_BIT = 13;
    localparam int SBC_CL_HI = 12;
    localparam int SBC_CL_LO = 11;
    localparam int SBC_NB_BIT = 7;
    localparam int SBC_BW_HI = 6;
    localparam int SBC_BW_LO = 5;
    localparam int SBC_COL_HI = 4;
    localparam int SBC_COL_LO = 3;
    localparam int SBC_SIZE_HI = 2;
    localparam int SBC_SIZE_LO = 0;

    localparam logic [1:0] SBC_BW_OFF = 2'h0;
    localparam logic [1:0] SBC_BW_BYTE = 2'h1;
    localparam logic [1:0] SBC_BW_HALF = 2'h2;
    localparam logic [1:0] SBC_CL_RSVD = 2'h3;
    localparam logic [1:0] SBC_COL_RSVD = 2'h3;
    localparam logic [3:0] SBC_COL_BASE = 4'h8;
    localparam logic [2:0] SBC_SIZE_OFF = 3'h0;
    localparam logic [2:0] SBC_SIZE_RSVD = 3'h7;
    // Size code 1 is 2 MB; each step doubles
    localparam logic [5:0] SBC_SIZE_LOG2_BASE = 6'h14;

    localparam int SBC_CLK_NS = 10;
    localparam int SBC_T_MRD_NS = 20;
    localparam int SBC_MRD_CYCLES = (SBC_T_MRD_NS + SBC_CLK_NS - 1) / SBC_CLK_NS;

    // Command pins {ras_n, cas_n, we_n}
    localparam logic [2:0] SBC_CMD_NOP = 3'h7;
    localparam logic [2:0] SBC_CMD_MRS = 3'h0;
    localparam int SBC_MODE_CL_LO = 4;
    localparam int SBC_MODE_W = 12;

    typedef enum logic [1:0] {
        SBC_IDLE = 2'b00,
        SBC_CMD = 2'b01,
        SBC_WAIT = 2'b10
    } sbc_mrs_state_type;

    function automatic logic [1:0] sbc_cl_clocks(input logic [1:0] code);
        sbc_cl_clocks = (code == SBC_CL_RSVD) ? 2'h0 : 2'(code + 2'h1);
    endfunction

    function automatic logic [3:0] sbc_col_bits(input logic [1:0] code);
        sbc_col_bits = (code == SBC_COL_RSVD) ? 4'h0 : 4'(SBC_COL_BASE + {2'h0, code});
    endfunction

    function automatic logic [31:0] sbc_start(input logic [31:0] cfg);
        sbc_start = 32'({cfg[SBC_BASE_HI:SBC_BASE_LO], {SBC_BASE_LO{1'b0}}} >> (SBC_BASE_LO - SBC_BASE_SHIFT));
    endfunction

    function automatic logic sbc_in_range(input logic [31:0] cfg, input logic [31:0] addr);
        logic [2:0] sz;
        logic [32:0] lim;
        sz = cfg[SBC_SIZE_HI:SBC_SIZE_LO];
        lim = {1'b0, sbc_start(cfg)} + (33'h1 << (SBC_SIZE_LOG2_BASE + {3'h0, sz}));
        sbc_in_range = cfg[SBC_BW_HI:SBC_BW_LO] != SBC_BW_OFF && sz != SBC_SIZE_OFF && sz != SBC_SIZE_RSVD
            && addr >= sbc_start(cfg) && {1'b0, addr} < lim;
    endfunction
endpackage

/* verif/sbc_bank_config_bench.sv */
// Purpose: Self-checking bench for the SDRAM bank configuration block
// Assumes: Wishbone slave acks one cycle after the request is taken
// Notes: Register writes land before the ack edge, so outputs are read one edge later
module sbc_bank_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] adr = '0, wdat = '0, mem_addr = '0;
    logic [3:0] sel = 4'hF;
    logic we = 1'b0, stb = 1'b0, cyc = 1'b0, mem_req = 1'b0;
    logic [31:0] wb_dat_o, cfg;
    logic wb_ack_o, ras_n, cas_n, we_n;
    logic [1:0] bank_hit, pre, ibc, mlr, cs_n;
    logic [1:0][31:0] bank_start;
    logic [1:0][1:0] cl, bw;
    logic [1:0][3:0] col;
    logic [sbc_pkg::SBC_MODE_W-1:0] maddr;
    logic [sbc_pkg::SBC_MODE_W-1:0] mode_word [2];
    int mrs_count [2];
    int err_count = 0, num_checks = 0;
    always #5 clk = ~clk;
    sbc_bank_config DUT (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_sel_i(sel), .wb_we_i(we), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(wb_ack_o),
        .mem_addr(mem_addr), .mem_req(mem_req), .bank_hit(bank_hit), .bank_start(bank_start),
        .precharge_select(pre), .cas_latency_clocks(cl), .internal_bank_count(ibc),
        .bank_bus_width(bw), .column_bits(col), .mode_load_request(mlr), .sdram_cs_n(cs_n),
        .sdram_ras_n(ras_n), .sdram_cas_n(cas_n), .sdram_we_n(we_n), .sdram_mode_addr(maddr));
    sbc_sdram_model MEM (.clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .mode_addr(maddr), .mrs_count(mrs_count), .mode_word(mode_word));
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    // Holds the request until ack is sampled, then releases for one cycle at least
    task automatic wb_xfer(input logic [31:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        wdat <= d;
        we <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk(1'b0, 1'b1, "no ack");
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(a, d, 1'b1, q);
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        wb_xfer(a, 32'h0, 1'b0, q);
        chk(q, exp, msg);
    endtask
    task automatic hit_chk(input logic [31:0] a, input logic [1:0] exp);
        @(posedge clk);
        mem_req <= 1'b1;
        mem_addr <= a;
        @(posedge clk);
        @(posedge clk);
        chk(32'(bank_hit), 32'(exp), "bank select");
        mem_req <= 1'b0;
    endtask
    task automatic wait_mrs(input int b);
        int n;
        n = 0;
        while (mlr[b] !== 1'b0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < 40), 32'h1, "mode set pending");
        // Let any late or repeated command reach the model before counting
        repeat (8) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_chk(sbc_pkg::SBC_BANK0_ADDR, 32'h0000_0800, "reset bank0");
        rd_chk(sbc_pkg::SBC_BANK1_ADDR, 32'h0000_0800, "reset bank1");
        wr(32'hFFF0_1010, 32'hFFFF_FFFF);
        rd_chk(32'hFFF0_1010, 32'h0, "unmapped read");
        // Reserved bits masked; bit 15 kept clear so no mode set starts
        wr(sbc_pkg::SBC_BANK0_ADDR, 32'hFFFF_7FFF);
        chk(bank_start[0], 32'h7FFC_0000, "start address");
        chk(32'({pre[0], ibc[0], bw[0]}), 32'h0F, "bank0 fields");
        chk(32'({cl[0], col[0]}), 32'h0, "reserved codes");
        rd_chk(sbc_pkg::SBC_BANK0_ADDR, 32'hFFF8_38FF, "reserved bits");
        rd_chk(sbc_pkg::SBC_BANK1_ADDR, 32'h0000_0800, "bank1 untouched");
        for (int i = 0; i < 3; i++) begin
            cfg = (i << 11) | ((i % 2 + 1) << 5) | (i << 3) | ((i == 1) << 13) | ((i == 2) << 7);
            wr(sbc_pkg::SBC_BANK1_ADDR, cfg);
            chk(32'(cl[1]), i + 1, "cas latency");
            chk(32'(col[1]), i + 8, "column bits");
            chk(32'(bw[1]), i % 2 + 1, "bus width");
            chk(32'({pre[1], ibc[1]}), {i == 1, i == 2}, "precharge and banks");
            rd_chk(sbc_pkg::SBC_BANK1_ADDR, cfg, "readback");
        end
        // Mode set on byte-wide bank 1 with latency 2
        wr(sbc_pkg::SBC_BANK1_ADDR, 32'h0000_8820);
        wait_mrs(1);
        chk(mrs_count[1], 1, "mode set count");
        chk(32'(mode_word[1]), 32'h020, "mode word");
        rd_chk(sbc_pkg::SBC_BANK1_ADDR, 32'h0000_0820, "mode bit cleared");
        // Disabled bank must not see a command
        wr(sbc_pkg::SBC_BANK0_ADDR, 32'h0000_8800);
        wait_mrs(0);
        chk(mrs_count[0] + mrs_count[1], 1, "disabled bank quiet");
        rd_chk(sbc_pkg::SBC_BANK0_ADDR, 32'h0000_0800, "disabled mode bit cleared");
        // Bank 1: start 0x40000, 2 MB; bank 0 same range but disabled
        wr(sbc_pkg::SBC_BANK1_ADDR, 32'h0008_0821);
        wr(sbc_pkg::SBC_BANK0_ADDR, 32'h0008_0801);
        chk(bank_start[1], 32'h0004_0000, "bank1 start address");
        hit_chk(32'h0004_0000, 2'h2);
        hit_chk(32'h0023_FFFF, 2'h2);
        hit_chk(32'h0024_0000, 2'h0);
        hit_chk(32'h0003_FFFF, 2'h0);
        summarize();
    end
    initial begin
        #100000;
        err_count++;
        summarize();
    end
endmodule // sbc_bank_config_bench

/* verif/sbc_sdram_model.sv */
// Purpose: Passive model of the two external SDRAM devices on the command pins
// Assumes: Commands sampled on the rising edge, one device per chip select
// Notes: Counts mode set commands and keeps the last mode word per device
module sbc_sdram_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sbc_pkg::SBC_MODE_W-1:0] mode_addr,
    output int mrs_count [2],
    output logic [sbc_pkg::SBC_MODE_W-1:0] mode_word [2]
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // Mode set is all three strobes low under one select; a device does not
    // see commands aimed at the other one
    always @(posedge clk) begin
        if (rst) begin
            mrs_count[0] <= 0;
            mrs_count[1] <= 0;
            mode_word[0] <= '0;
            mode_word[1] <= '0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (cs_n[b] === 1'b0 && {ras_n, cas_n, we_n} === sbc_pkg::SBC_CMD_MRS) begin
                    mrs_count[b] <= mrs_count[b] + 1;
                    mode_word[b] <= mode_addr;
                end
            end
        end
    end
endmodule // sbc_sdram_model
